// [inc/cafm_regs.vh]
`ifndef CAFM_REGS_VH
`define CAFM_REGS_VH
// =====================================================
// Register offsets (byte addresses on the internal register port)
`define CAFM_F0_EXT_MID 8'h02
`define CAFM_F0_EXT_LOW 8'h03
`define CAFM_F1_EXT_MID 8'h06
`define CAFM_F1_EXT_LOW 8'h07
`define CAFM_F2_EXT_MID 8'h0A
`define CAFM_F2_EXT_LOW 8'h0B
`define CAFM_F3_EXT_MID 8'h12
`define CAFM_F3_EXT_LOW 8'h13
`define CAFM_F4_EXT_MID 8'h16
`define CAFM_F4_EXT_LOW 8'h17
`define CAFM_F5_EXT_MID 8'h1A
`define CAFM_F5_EXT_LOW 8'h1B
`define CAFM_M0_STD_HIGH 8'h20
`define CAFM_M0_STD_LOW 8'h21
`define CAFM_M0_EXT_MID 8'h22
`define CAFM_M0_EXT_LOW 8'h23
`define CAFM_M1_STD_HIGH 8'h24
`define CAFM_M1_STD_LOW 8'h25
`define CAFM_M1_EXT_MID 8'h26
`define CAFM_M1_EXT_LOW 8'h27
// =====================================================
// Field layout of the mask standard-identifier low byte
`define CAFM_SL_SID_MASK 8'hE0
`define CAFM_SL_EID_MASK 8'h03
`define CAFM_SL_IMPL_MASK 8'hE3
// =====================================================
// Reset values (power-on value is undefined; zero chosen)
`define CAFM_REG_RST 8'h00
`define CAFM_HIT_RST 3'h0
`endif

// [core/cafm_filter_regs.v]
// Notes on behaviour
// - Each of six filters has a byte at 03h,07h,0Bh,13h,17h,1Bh matched to extended id bits 7..0.
// - Each of six filters has a byte at 02h,06h,0Ah,12h,16h,1Ah matched to extended id bits 15..8.
// - Each mask has a byte at 20h/24h masking standard id bits 10..3.
// - Bits 7..5 of the mask byte at 21h/25h mask standard id bits 2..0.
// - Bits 4..2 of the mask byte at 21h/25h ignore writes and read as zero.
// - Bits 1..0 of the mask byte at 21h/25h mask extended id bits 17..16.
// - Each mask has a byte at 22h/26h masking extended id bits 15..8.
// - Each mask has a byte at 23h/27h masking extended id bits 7..0.
// - A bit accepts when its mask is zero, else only when filter and received bits agree.
// - Mask zero serves filters zero and one, mask one serves filters two to five.
// - With several matches the lowest-numbered matching filter of each mask's group becomes that mask's hit code.
// - Filter and mask registers change only in configuration mode.
`include "cafm_regs.vh"

module cafm_filter_regs (
	// Clock and reset
	input wire i_mclk,
	input wire i_sys_rst,
	// Register port
	input wire i_reg_wr,
	input wire i_reg_rd,
	input wire [7:0] i_reg_addr,
	input wire [7:0] i_reg_wdata,
	output reg [7:0] o_reg_rdata,
	// Mode
	input wire i_cfg_mode,
	// Received identifier and upper filter bytes held elsewhere
	input wire [10:0] i_rx_std_id,
	input wire [17:0] i_rx_ext_id,
	input wire [47:0] i_flt_std_high,
	input wire [17:0] i_flt_std_low,
	// Per-bit match results and hit codes
	output reg [5:0] o_flt_match,
	output reg [28:0] o_bit_ok0,
	output reg [28:0] o_bit_ok1,
	output reg o_hit_valid0,
	output reg [2:0] o_filter_hit_code0,
	output reg o_hit_valid1,
	output reg [2:0] o_filter_hit_code1
);

	// =====================================================
	// Storage
	reg [7:0] flt_mid_ff [0:5];
	reg [7:0] flt_low_ff [0:5];
	reg [7:0] msk_sh_ff [0:1];
	reg [7:0] msk_sl_ff [0:1];
	reg [7:0] msk_em_ff [0:1];
	reg [7:0] msk_el_ff [0:1];

	// Filter slot for an offset, 7 when not a filter byte
	function [2:0] flt_slot;
		input [7:0] a;
		begin
			case (a & 8'hFE)
				`CAFM_F0_EXT_MID: flt_slot = 3'h0;
				`CAFM_F1_EXT_MID: flt_slot = 3'h1;
				`CAFM_F2_EXT_MID: flt_slot = 3'h2;
				`CAFM_F3_EXT_MID: flt_slot = 3'h3;
				`CAFM_F4_EXT_MID: flt_slot = 3'h4;
				`CAFM_F5_EXT_MID: flt_slot = 3'h5;
				default: flt_slot = 3'h7;
			endcase
		end
	endfunction

	wire [2:0] wr_slot;
	wire wr_ok;
	wire msk_hit;
	wire msk_sel;
	assign wr_slot = flt_slot(i_reg_addr);
	// Writes outside configuration mode are dropped silently
	assign wr_ok = i_reg_wr & i_cfg_mode;
	assign msk_hit = (i_reg_addr[7:3] == 5'h04);
	assign msk_sel = i_reg_addr[2];

	// =====================================================
	// Register writes
	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_flt
			always @(posedge i_mclk or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					flt_mid_ff[g] <= `CAFM_REG_RST;
					flt_low_ff[g] <= `CAFM_REG_RST;
				end else if (wr_ok && wr_slot == g) begin
					if (i_reg_addr[0]) begin
						flt_low_ff[g] <= i_reg_wdata;
					end else begin
						flt_mid_ff[g] <= i_reg_wdata;
					end
				end
			end
		end
		for (g = 0; g < 2; g = g + 1) begin : g_msk
			always @(posedge i_mclk or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					msk_sh_ff[g] <= `CAFM_REG_RST;
					msk_sl_ff[g] <= `CAFM_REG_RST;
					msk_em_ff[g] <= `CAFM_REG_RST;
					msk_el_ff[g] <= `CAFM_REG_RST;
				end else if (wr_ok && msk_hit && msk_sel == g) begin
					case (i_reg_addr[1:0])
						2'h0: msk_sh_ff[g] <= i_reg_wdata;
						2'h1: msk_sl_ff[g] <= i_reg_wdata & `CAFM_SL_IMPL_MASK;
						2'h2: msk_em_ff[g] <= i_reg_wdata;
						default: msk_el_ff[g] <= i_reg_wdata;
					endcase
				end
			end
		end
	endgenerate

	// =====================================================
	// Read mux, unmapped offsets read zero
	reg [7:0] nxt_rdata;
	always @* begin
		nxt_rdata = 8'h00;
		if (wr_slot != 3'h7) begin
			nxt_rdata = i_reg_addr[0] ? flt_low_ff[wr_slot] : flt_mid_ff[wr_slot];
		end else if (msk_hit) begin
			case (i_reg_addr[1:0])
				2'h0: nxt_rdata = msk_sh_ff[msk_sel];
				2'h1: nxt_rdata = msk_sl_ff[msk_sel];
				2'h2: nxt_rdata = msk_em_ff[msk_sel];
				default: nxt_rdata = msk_el_ff[msk_sel];
			endcase
		end
	end

	always @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_reg_rdata <= `CAFM_REG_RST;
		end else if (i_reg_rd) begin
			o_reg_rdata <= nxt_rdata;
		end
	end

	// =====================================================
	// Matching
	wire [28:0] rx_id;
	wire [28:0] msk_vec [0:1];
	wire [28:0] flt_vec [0:5];
	wire [5:0] flt_ok;
	assign rx_id = {i_rx_std_id, i_rx_ext_id};
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_mv
			// Standard id on top, extended id 17..0 below
			assign msk_vec[g] = {msk_sh_ff[g], msk_sl_ff[g][7:5], msk_sl_ff[g][1:0],
				msk_em_ff[g], msk_el_ff[g]};
		end
		for (g = 0; g < 6; g = g + 1) begin : g_fv
			// Mask zero for filters 0-1, mask one for 2-5
			// Filter ext id 17..16 is not held here, taken as zero
			assign flt_vec[g] = {i_flt_std_high[g*8 +: 8], i_flt_std_low[g*3 +: 3],
				2'h0, flt_mid_ff[g], flt_low_ff[g]};
			assign flt_ok[g] = &(~msk_vec[g < 2 ? 0 : 1] | ~(flt_vec[g] ^ rx_id));
		end
	endgenerate

	// Lowest-numbered match wins
	function [2:0] first_hit;
		input [5:0] m;
		begin
			if (m[0]) first_hit = 3'h0;
			else if (m[1]) first_hit = 3'h1;
			else if (m[2]) first_hit = 3'h2;
			else if (m[3]) first_hit = 3'h3;
			else if (m[4]) first_hit = 3'h4;
			else first_hit = 3'h5;
		end
	endfunction

	always @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_flt_match <= 6'h00;
			o_bit_ok0 <= 29'h0;
			o_bit_ok1 <= 29'h0;
			o_hit_valid0 <= 1'b0;
			o_hit_valid1 <= 1'b0;
			o_filter_hit_code0 <= `CAFM_HIT_RST;
			o_filter_hit_code1 <= `CAFM_HIT_RST;
		end else begin
			o_flt_match <= flt_ok;
			o_bit_ok0 <= ~msk_vec[0] | ~(flt_vec[0] ^ rx_id);
			o_bit_ok1 <= ~msk_vec[1] | ~(flt_vec[2] ^ rx_id);
			o_hit_valid0 <= |flt_ok[1:0];
			o_hit_valid1 <= |flt_ok[5:2];
			o_filter_hit_code0 <= first_hit({4'h0, flt_ok[1:0]});
			o_filter_hit_code1 <= first_hit({flt_ok[5:2], 2'h0});
		end
	end

endmodule // cafm_filter_regs

// [verif/cafm_chk_asserts.sv]
module cafm_chk (
	// Clock, reset
	input wire i_mclk,
	input wire i_sys_rst,
	// Ports watched
	input wire i_reg_wr,
	input wire i_reg_rd,
	input wire [7:0] i_reg_addr,
	input wire [7:0] i_reg_wdata,
	input wire i_cfg_mode,
	input wire [7:0] o_reg_rdata,
	input wire [5:0] o_flt_match,
	input wire [28:0] o_bit_ok0,
	input wire [28:0] o_bit_ok1,
	input wire o_hit_valid0,
	input wire [2:0] o_filter_hit_code0,
	input wire o_hit_valid1,
	input wire [2:0] o_filter_hit_code1
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_sys_rst);
	// =====
	// Mask bytes, low std byte apart
	sequence s_wr;
		i_reg_wr && i_cfg_mode && i_reg_addr[7:3] == 5'h04 && i_reg_addr[1:0] != 2'h1;
	endsequence
	sequence s_rd;
		i_reg_rd && i_reg_addr == $past(i_reg_addr, 2);
	endsequence
	property p_wr;
		s_wr ##2 s_rd |=> o_reg_rdata == $past(i_reg_wdata, 3);
	endproperty
	a_wr: assert property (p_wr) else $error("readback");
	property p_rz;
		i_reg_rd && i_reg_addr[7:3] == 5'h04 && i_reg_addr[1:0] == 2'h1 |=> o_reg_rdata[4:2] == 3'h0;
	endproperty
	a_rz: assert property (p_rz) else $error("bits 4..2");
	property p_v0;
		o_hit_valid0 == |o_flt_match[1:0];
	endproperty
	a_v0: assert property (p_v0) else $error("valid0");
	property p_v1;
		o_hit_valid1 == |o_flt_match[5:2];
	endproperty
	a_v1: assert property (p_v1) else $error("valid1");
	property p_c0;
		o_hit_valid0 |-> o_filter_hit_code0 == (o_flt_match[0] ? 3'h0 : 3'h1);
	endproperty
	a_c0: assert property (p_c0) else $error("code0");
	property p_c1;
		o_hit_valid1 |-> o_filter_hit_code1 == (o_flt_match[2] ? 3'h2 :
			o_flt_match[3] ? 3'h3 : o_flt_match[4] ? 3'h4 : 3'h5);
	endproperty
	a_c1: assert property (p_c1) else $error("code1");
	property p_b0;
		o_flt_match[0] == &o_bit_ok0;
	endproperty
	a_b0: assert property (p_b0) else $error("bits0");
	property p_b1;
		o_flt_match[2] == &o_bit_ok1;
	endproperty
	a_b1: assert property (p_b1) else $error("bits1");
endmodule // cafm_chk

// [verif/cafm_host.sv]
module cafm_host (
	// Clock, read data
	input wire logic i_mclk,
	input wire logic [7:0] i_rdata,
	// Register port
	output logic o_wr = 1'b0,
	output logic o_rd = 1'b0,
	output logic o_cfg = 1'b1,
	output logic [7:0] o_addr = 8'h00,
	output logic [7:0] o_wdata = 8'h00
);
	timeunit 1ns;
	timeprecision 1ps;
	task wr(input logic [7:0] a, input logic [7:0] w);
		@(posedge i_mclk);
		o_wr <= 1'b1;
		o_addr <= a;
		o_wdata <= w;
		@(posedge i_mclk);
		o_wr <= 1'b0;
		// Idle lines never keep the last value
		o_addr <= ~a;
		o_wdata <= ~w;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] r);
		@(posedge i_mclk);
		o_rd <= 1'b1;
		o_addr <= a;
		@(posedge i_mclk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		#1 r = i_rdata;
	endtask
	task mode(input logic c);
		@(posedge i_mclk);
		o_cfg <= c;
	endtask
endmodule // cafm_host

// [verif/tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_mclk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_reg_wr, i_reg_rd, i_cfg_mode;
	logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, d, a, w;
	logic [17:0] i_rx_ext_id = 18'h00000;
	logic [10:0] rx_std = 11'h000;
	logic [47:0] flt_hi = 48'h0;
	logic [17:0] flt_lo = 18'h0;
	logic v0, v1;
	logic [2:0] c0, c1;
	logic [7:0] h;
	logic [5:0] o_flt_match, e;
	int n_mismatch = 0;
	int check_count = 0;
	always #2 i_mclk = ~i_mclk;
	cafm_host i_host (.i_mclk(i_mclk), .i_rdata(o_reg_rdata), .o_wr(i_reg_wr),
		.o_rd(i_reg_rd), .o_cfg(i_cfg_mode), .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
	cafm_filter_regs i_dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.o_reg_rdata(o_reg_rdata), .i_cfg_mode(i_cfg_mode), .i_rx_std_id(rx_std),
		.i_rx_ext_id(i_rx_ext_id), .i_flt_std_high(flt_hi), .i_flt_std_low(flt_lo),
		.o_flt_match(o_flt_match), .o_bit_ok0(), .o_bit_ok1(), .o_hit_valid0(v0),
		.o_filter_hit_code0(c0), .o_hit_valid1(v1), .o_filter_hit_code1(c1));
	task chk(input logic [7:0] s, input logic [7:0] x);
		check_count++;
		if (s !== x) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h want %h", $time, s, x);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#20000;
		n_mismatch++;
		stop_test();
	end
	initial begin
		repeat (20) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		// =====
		// Masks: low std byte FC so id bits 17..16 pass
		for (int m = 0; m < 8; m++) begin
			a = 8'h20 + 8'(m);
			i_host.wr(a, (m % 4 == 1) ? 8'hFC : 8'hFF);
			i_host.rd(a, d);
			chk(d, (m % 4 == 1) ? 8'hE0 : 8'hFF);
		end
		// Filter 4 copies filter 2 to force a tie
		for (int g = 0; g < 12; g++) begin
			a = (g > 5 ? 8'h10 : 8'h00) + 8'(g / 2 % 3 * 4 + 2 + g % 2);
			w = (g % 2 ? 8'h20 : 8'h10) + (g / 2 == 4 ? 8'h02 : 8'(g / 2));
			i_host.wr(a, w);
			i_host.rd(a, d);
			chk(d, w);
		end
		i_host.mode(1'b0);
		i_host.wr(8'h23, 8'h00);
		i_host.rd(8'h23, d);
		chk(d, 8'hFF);
		for (int x = 0; x < 6; x++) begin
			@(posedge i_mclk);
			i_rx_ext_id <= {2'h0, 8'h10 + 8'(x), 8'h20 + 8'(x)};
			for (int g = 0; g < 6; g++)
				e[g] = ((g == 4 ? 2 : g) == x);
			h = {x < 2 ? {1'b1, 3'(x)} : 4'h0, (x > 1 && x != 4) ? {1'b1, 3'(x)} : 4'h0};
			repeat (2) @(posedge i_mclk);
			#1 chk({2'h0, o_flt_match}, {2'h0, e});
			chk({v0, v0 ? c0 : 3'h0, v1, v1 ? c1 : 3'h0}, h);
		end
		// Standard id bits must line up above the extended ones
		@(posedge i_mclk);
		rx_std <= 11'h2AD;
		flt_hi <= 48'h000000000055;
		flt_lo <= 18'h00005;
		i_rx_ext_id <= {2'h0, 8'h10, 8'h20};
		repeat (2) @(posedge i_mclk);
		#1 chk({2'h0, o_flt_match}, 8'h01);
		stop_test();
	end
endmodule // tb
bind cafm_filter_regs cafm_chk i_chk (.*);
